/* logic/sleep_mode_controller.sv */
// sleep mode controller: idle/sleep decision, wake sources, clear-to-send and alerts
`timescale 1ns/1ps
module sleep_mode_controller
  import sleep_pkg::*;
#(
  parameter longint SECOND_CYCLES_P = sleep_pkg::SECOND_CYCLES,
  parameter longint PAGE_PERIOD_P   = sleep_pkg::PAGE_PERIOD_CYCLES,
  parameter longint PAGE_LEN_P      = sleep_pkg::PAGE_LEN_CYCLES,
  parameter int     STABILISE_P     = sleep_pkg::STABILISE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        uart_rx_active,
  input  wire logic        uart_tx_active,
  input  wire logic        network_busy,
  input  wire logic        network_indication,
  input  wire logic        usb_connected,
  input  wire logic        usb_transaction,
  input  wire logic        wake_request_low,
  output logic             cts_low,
  output logic             wake_out_low,
  output logic             ring_indicator_low,
  output logic             serial_alert,
  output logic             serial_enable,
  output logic             sleeping
);
  import sleep_pkg::*;

  logic [31:0] ctrl_reg;
  logic [7:0]  inact_reg;
  logic        ph_valid_reg;
  logic        ph_write_reg;
  logic [7:0]  ph_addr_reg;
  logic        alert_done;
  op_state_t   state_reg;
  logic [31:0] tick_reg;
  logic [7:0]  sec_reg;
  logic [31:0] page_reg;
  logic [31:0] stab_reg;
  logic        alert_pend_reg;
  logic        cts_low_reg;
  logic        blocking;
  logic        timeout;
  logic        wake_any;
  logic        sleep_ok;

  wire sleep_en  = ctrl_reg[SLEEP_EN_BIT];
  wire cts_block = ctrl_reg[CTS_BLOCK_BIT];
  wire hw_flow   = ctrl_reg[HW_FLOW_BIT];
  wire usb_sr    = ctrl_reg[USB_SR_BIT];
  wire [1:0] alert_sel = ctrl_reg[ALERT_MSB:ALERT_LSB];
  wire task_busy = ctrl_reg[TASK_BIT];

  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (hready) begin
      ph_valid_reg <= hsel & htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg  <= haddr[7:0];
    end
  end

  wire wr = ph_valid_reg & ph_write_reg;
  assign alert_done = wr && ph_addr_reg == EVENT_OFF && hwdata[EV_ALERT_DONE_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= CTRL_RESET;
      inact_reg <= INACT_RESET;
    end else if (wr) begin
      if (ph_addr_reg == CTRL_OFF)
        ctrl_reg <= {25'h0, hwdata[TASK_BIT:0]};
      if (ph_addr_reg == INACT_OFF)
        inact_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        CTRL_OFF:   hrdata <= ctrl_reg;
        INACT_OFF:  hrdata <= {24'h0, inact_reg};
        STATUS_OFF: hrdata <= {27'h0, ~ring_indicator_low, ~wake_out_low, cts_low_reg, state_reg};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // activity that holds the device awake
  assign blocking = uart_rx_active | uart_tx_active | network_busy | task_busy
                  | ~wake_request_low
                  | (usb_connected & ~usb_sr)
                  | (usb_connected & usb_transaction)
                  | alert_pend_reg;
  assign timeout  = sec_reg >= inact_reg;
  assign sleep_ok = sleep_en & ~blocking & timeout;

  // inactivity seconds counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 32'h0;
      sec_reg  <= 8'h00;
    end else if (blocking || state_reg != ST_IDLE) begin
      tick_reg <= 32'h0;
      sec_reg  <= 8'h00;
    end else if (!timeout) begin
      if (tick_reg == 32'(SECOND_CYCLES_P - 1)) begin
        tick_reg <= 32'h0;
        sec_reg  <= sec_reg + 8'h01;
      end else begin
        tick_reg <= tick_reg + 32'h1;
      end
    end
  end

  assign wake_any = ~wake_request_low
                  | uart_rx_active
                  | (usb_sr & usb_transaction)
                  | network_indication
                  | ~sleep_en;

  // operating state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      page_reg  <= 32'h0;
      stab_reg  <= 32'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          page_reg <= 32'h0;
          if (sleep_ok)
            state_reg <= ST_SLEEP;
        end
        ST_SLEEP, ST_PAGING: begin
          if (wake_any) begin
            state_reg <= ST_WAKING;
            stab_reg  <= 32'h0;
          end else if (page_reg == 32'(PAGE_PERIOD_P - 1)) begin
            page_reg  <= 32'h0;
            state_reg <= ST_PAGING;
          end else begin
            page_reg <= page_reg + 32'h1;
            if (state_reg == ST_PAGING && page_reg == 32'(PAGE_LEN_P - 1))
              state_reg <= ST_SLEEP;
          end
        end
        ST_WAKING: begin
          if (stab_reg == 32'(STABILISE_P - 1))
            state_reg <= ST_IDLE;
          else
            stab_reg <= stab_reg + 32'h1;
        end
      endcase
    end
  end

  // clear-to-send
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_low_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && sleep_ok && usb_connected) begin
      cts_low_reg <= cts_low_reg;
    end else begin
      unique case (state_reg)
        // cts_low_reg is the pin level: 1 means serial port closed
        ST_IDLE:    cts_low_reg <= sleep_ok & hw_flow;
        ST_SLEEP:   cts_low_reg <= usb_connected ? cts_low_reg : hw_flow;
        ST_PAGING:  cts_low_reg <= usb_connected ? cts_low_reg : cts_block;
        ST_WAKING:  cts_low_reg <= (stab_reg != 32'(STABILISE_P - 1));
      endcase
    end
  end

  // network alert to the application
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      alert_pend_reg <= 1'b0;
    else if (network_indication)
      alert_pend_reg <= 1'b1;
    else if (alert_done)
      alert_pend_reg <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_out_low       <= 1'b1;
      ring_indicator_low <= 1'b1;
      serial_alert       <= 1'b0;
    end else begin
      wake_out_low       <= ~(alert_pend_reg && alert_sel == ALERT_WAKE_OUT);
      ring_indicator_low <= ~(alert_pend_reg && alert_sel == ALERT_RING);
      serial_alert       <= alert_pend_reg && alert_sel == ALERT_SERIAL;
    end
  end

  assign cts_low       = cts_low_reg;
  assign serial_enable = (state_reg == ST_IDLE) | (state_reg == ST_PAGING && !cts_block);
  assign sleeping      = (state_reg == ST_SLEEP) | (state_reg == ST_PAGING);
endmodule : sleep_mode_controller

/* logic/sleep_pkg.sv */
// constants, register map and types of the sleep mode controller
package sleep_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] INACT_OFF  = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] EVENT_OFF  = 8'h0c;
  // control register fields
  localparam int SLEEP_EN_BIT  = 0;
  localparam int CTS_BLOCK_BIT = 1;
  localparam int HW_FLOW_BIT   = 2;
  localparam int USB_SR_BIT    = 3;
  localparam int ALERT_LSB     = 4;
  localparam int ALERT_MSB     = 5;
  localparam int TASK_BIT      = 6;
  // status register fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_STATE_MSB  = 1;
  localparam int ST_CTS_BIT    = 2;
  localparam int ST_WAKE_BIT   = 3;
  localparam int ST_RING_BIT   = 4;
  // event register: write 1 to pulse
  localparam int EV_ALERT_DONE_BIT = 0;
  // reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_000c;
  localparam logic [7:0]  INACT_RESET = 8'h05;
  // alert methods
  localparam logic [1:0] ALERT_WAKE_OUT = 2'h0;
  localparam logic [1:0] ALERT_SERIAL   = 2'h1;
  localparam logic [1:0] ALERT_RING     = 2'h2;
  // timing
  localparam longint CLK_HZ            = 125_000_000;
  localparam longint SECOND_CYCLES     = CLK_HZ;
  localparam int     STABILISE_US      = 100;
  localparam int     STABILISE_CYCLES  = (STABILISE_US * 125);
  localparam int     PAGE_PERIOD_MS    = 1000;
  localparam int     PAGE_LEN_MS       = 10;
  localparam longint PAGE_PERIOD_CYCLES = (longint'(PAGE_PERIOD_MS) * CLK_HZ) / 1000;
  localparam longint PAGE_LEN_CYCLES    = (longint'(PAGE_LEN_MS) * CLK_HZ) / 1000;
  // operating states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SLEEP,
    ST_PAGING,
    ST_WAKING
  } op_state_t;
endpackage : sleep_pkg

/* verif/host_app.sv */
// host model: wakes the device, waits for clear-to-send, sends serial data
`timescale 1ns/1ps
module host_app (
  input  wire logic hclk,
  input  wire logic go,
  input  wire logic cts_low,
  output logic      wake_request_low,
  output logic      uart_rx_active,
  output logic      done
);
  initial begin
    wake_request_low = 1'b1;
    uart_rx_active = 1'b0;
    done = 1'b0;
  end
  always @(posedge hclk) begin
    if (go && !done) begin
      wake_request_low <= 1'b0;
      repeat (2) @(posedge hclk);
      while (cts_low !== 1'b0) @(posedge hclk);
      uart_rx_active <= 1'b1;
      repeat (3) @(posedge hclk);
      uart_rx_active <= 1'b0;
      wake_request_low <= 1'b1;
      done <= 1'b1;
    end else if (!go) begin
      done <= 1'b0;
    end
  end
endmodule : host_app

/* verif/sleep_chk.sv */
// port checker for the sleep mode controller
`timescale 1ns/1ps
module sleep_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic uart_rx_active,
  input wire logic uart_tx_active,
  input wire logic network_busy,
  input wire logic network_indication,
  input wire logic usb_connected,
  input wire logic usb_transaction,
  input wire logic wake_request_low,
  input wire logic cts_low,
  input wire logic wake_out_low,
  input wire logic ring_indicator_low,
  input wire logic serial_enable,
  input wire logic sleeping
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reset_idle_a:
    assert property ($rose(hresetn) |-> !sleeping && serial_enable && !cts_low && wake_out_low && ring_indicator_low)
      else $error("not idle after reset");
  busy_no_sleep_a:
    assert property ($rose(sleeping) |-> !$past(uart_rx_active) && !$past(uart_tx_active) && !$past(network_busy))
      else $error("slept while busy");
  usb_no_sleep_a:
    assert property ($rose(sleeping) |-> !$past(usb_connected && usb_transaction)) else $error("slept during usb");
  wake_req_a:
    assert property (!wake_request_low |=> !sleeping) else $error("asleep with wake request");
  rx_wake_a:
    assert property (uart_rx_active |=> !sleeping) else $error("asleep with rx activity");
  net_wake_a:
    assert property (sleeping && network_indication |=> !sleeping) else $error("no wake on indication");
  tx_hold_a:
    assert property (uart_tx_active && !sleeping |=> !sleeping) else $error("slept during tx");
  stabilise_a:
    assert property ($fell(sleeping) |-> !serial_enable [*3]) else $error("serial on before stable");
  cover property ($rose(sleeping));
  cover property ($fell(sleeping));
  cover property (sleeping && serial_enable);
endmodule : sleep_chk
bind sleep_mode_controller sleep_chk chk (.hclk, .hresetn, .uart_rx_active, .uart_tx_active, .network_busy,
  .network_indication, .usb_connected, .usb_transaction, .wake_request_low, .cts_low, .wake_out_low,
  .ring_indicator_low, .serial_enable, .sleeping);

/* verif/tb_top.sv */
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
module tb_top;
  import sleep_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, go = 0, done;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic uart_rx_active, uart_tx_active = 0, network_busy = 0, network_indication = 0, usb_connected = 0;
  logic usb_transaction = 0, wake_request_low, cts_low, wake_out_low, ring_indicator_low;
  logic serial_alert, serial_enable, sleeping;
  int n_errors = 0, total_checks = 0;
  always #4 hclk = ~hclk;
  sleep_mode_controller #(.SECOND_CYCLES_P(20), .PAGE_PERIOD_P(50), .PAGE_LEN_P(5), .STABILISE_P(4)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .uart_rx_active, .uart_tx_active, .network_busy, .network_indication,
    .usb_connected, .usb_transaction, .wake_request_low, .cts_low, .wake_out_low, .ring_indicator_low,
    .serial_alert, .serial_enable, .sleeping);
  host_app host (.hclk, .go, .cts_low, .wake_request_low, .uart_rx_active, .done);
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task wsl(input logic v);
    for (int i = 0; i < 300 && sleeping !== v; i++) @(posedge hclk);
    chk({31'h0, sleeping}, {31'h0, v});
  endtask : wsl
  task paging;
    for (int i = 0; i < 120 && !(sleeping && serial_enable); i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : paging
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #40000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    bus(0, CTRL_OFF, 0); chk(q, CTRL_RESET);
    bus(0, INACT_OFF, 0); chk(q, 32'h5);
    bus(0, STATUS_OFF, 0); chk(q, 32'h0);
    bus(0, 8'h10, 0); chk(q, 32'h0);
    $display("reset test done");
    bus(1, INACT_OFF, 0); bus(1, CTRL_OFF, 32'h0d);
    wsl(1);
    repeat (3) @(posedge hclk);
    chk({31'h0, cts_low}, 32'h1);
    go <= 1'b1;
    wsl(0);
    chk({31'h0, cts_low}, 32'h1);
    for (int i = 0; i < 100 && uart_rx_active !== 1'b1; i++) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge hclk);
    go <= 1'b0;
    wsl(1);
    paging();
    chk({31'h0, cts_low}, 32'h0);
    bus(1, CTRL_OFF, 32'h0f);
    repeat (10) @(posedge hclk);
    paging();
    chk({31'h0, cts_low}, 32'h1);
    bus(1, CTRL_OFF, 32'h0c);
    wsl(0);
    repeat (40) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    $display("sleep and wake test done");
    bus(1, INACT_OFF, 1); network_busy <= 1'b1; bus(1, CTRL_OFF, 32'h0d);
    repeat (40) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    network_busy <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    wsl(1);
    network_indication <= 1'b1;
    @(posedge hclk);
    network_indication <= 1'b0;
    wsl(0);
    repeat (2) @(posedge hclk);
    chk({31'h0, wake_out_low}, 32'h0);
    chk({30'h0, ring_indicator_low, serial_alert}, 32'h2);
    bus(1, EVENT_OFF, 1); uart_tx_active <= 1'b1;
    repeat (40) @(posedge hclk);
    chk({30'h0, wake_out_low, sleeping}, 32'h2);
    uart_tx_active <= 1'b0;
    wsl(1);
    usb_connected <= 1'b1; usb_transaction <= 1'b1;
    @(posedge hclk);
    usb_transaction <= 1'b0;
    wsl(0);
    bus(1, CTRL_OFF, 32'h05);
    repeat (40) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h0);
    usb_connected <= 1'b0;
    wsl(1);
    $display("activity test done");
    report_and_stop();
  end
endmodule : tb_top
